// >>> hw/deep_sleep_clock_gate_bank_one.sv
`timescale 1ns/1ps
module deep_sleep_clock_gate_bank_one (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  input  wire logic [31:0] unit_access,
  output logic [31:0]      unit_clock_enable,
  output logic [31:0]      unit_disable,
  output logic             unit_bus_fault,
  output logic             irq
);
  localparam logic [1:0] resp_okay  = 2'b00;
  localparam logic [1:0] resp_error = 2'b10;

  logic [31:0] run_peripheral_gate_one, next_run;
  logic [31:0] sleep_peripheral_gate_one, next_sleep;
  logic [31:0] deep_sleep_peripheral_gate_one, next_deep;
  logic        auto_gating_select, next_auto;
  logic [1:0]  power_mode, next_mode;
  logic [31:0] irq_status, next_status;
  logic [31:0] irq_mask, next_mask;
  logic [31:0] fault_unit, next_fault_unit;
  logic        served, next_served;
  logic [31:0] next_readdata;
  logic [1:0]  next_response;
  logic [31:0] active_gate, next_enable;
  logic        fault_now;
  logic [31:0] fault_units_now;

  function automatic logic [31:0] merge_write(input logic [31:0] old_value,
                                              input logic [31:0] data,
                                              input logic [3:0]  lanes,
                                              input logic [31:0] writable);
    logic [31:0] lane_mask;
    lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}} & writable;
    merge_write = (old_value & ~lane_mask) | (data & lane_mask);
  endfunction

  // True for every offset that the register file answers with an okay response.
  function automatic logic is_mapped(input logic [11:0] offset);
    is_mapped = offset == gate_bank_pkg::deep_sleep_gate_offset ||
                offset == gate_bank_pkg::run_gate_offset ||
                offset == gate_bank_pkg::sleep_gate_offset ||
                offset == gate_bank_pkg::control_offset ||
                offset == gate_bank_pkg::irq_status_offset ||
                offset == gate_bank_pkg::irq_mask_offset ||
                offset == gate_bank_pkg::fault_unit_offset;
  endfunction

  // The gating vectors are one bit per unit, so the unit count must fill the bus word.
  initial begin
    if (gate_bank_pkg::unit_count != 32) begin
      $error("unit_count must be 32");
    end
  end

  // Gating source per mode; deep-sleep falls back to run gating without auto select.
  always_comb begin
    unique case (power_mode)
      gate_bank_pkg::mode_run:   active_gate = run_peripheral_gate_one;
      gate_bank_pkg::mode_sleep:
        active_gate = auto_gating_select ? sleep_peripheral_gate_one
                                         : run_peripheral_gate_one;
      gate_bank_pkg::mode_deep_sleep:
        active_gate = auto_gating_select ? deep_sleep_peripheral_gate_one // R10
                                         : run_peripheral_gate_one; // R12
      default:                   active_gate = run_peripheral_gate_one;
    endcase
    next_enable = active_gate & gate_bank_pkg::gate_writable_mask; // R1 R5 R6 R7 R8 R11
  end

  unit_fault_check #(
    .units(gate_bank_pkg::unit_count)
  ) fault_check (
    .unit_clock_on(unit_clock_enable),
    .unit_access  (unit_access),
    .fault        (fault_now),
    .fault_units  (fault_units_now)
  );

  // Register bus: every access answers on the cycle after it is seen, then re-arms.
  always_comb begin
    next_run        = run_peripheral_gate_one;
    next_sleep      = sleep_peripheral_gate_one;
    next_deep       = deep_sleep_peripheral_gate_one;
    next_auto       = auto_gating_select;
    next_mode       = power_mode;
    next_mask       = irq_mask;
    next_status     = irq_status;
    next_fault_unit = fault_unit;
    next_served     = 1'b0;
    next_readdata   = readdata;
    next_response   = response;
    if ((read || write) && !served) begin
      next_served   = 1'b1;
      next_readdata = gate_bank_pkg::unmapped_read_value;
      next_response = resp_okay;
      unique case (address)
        gate_bank_pkg::deep_sleep_gate_offset: begin // R4
          if (write)
            next_deep = merge_write(deep_sleep_peripheral_gate_one, writedata, byteenable,
                                    gate_bank_pkg::gate_writable_mask); // R9
          next_readdata = deep_sleep_peripheral_gate_one;
        end
        gate_bank_pkg::run_gate_offset: begin
          if (write)
            next_run = merge_write(run_peripheral_gate_one, writedata, byteenable,
                                   gate_bank_pkg::gate_writable_mask);
          next_readdata = run_peripheral_gate_one;
        end
        gate_bank_pkg::sleep_gate_offset: begin
          if (write)
            next_sleep = merge_write(sleep_peripheral_gate_one, writedata, byteenable,
                                     gate_bank_pkg::gate_writable_mask);
          next_readdata = sleep_peripheral_gate_one;
        end
        gate_bank_pkg::control_offset: begin
          if (write && byteenable[0]) begin
            next_auto = writedata[gate_bank_pkg::control_auto_gating_bit];
            next_mode = writedata[gate_bank_pkg::control_mode_lsb +: 2];
          end
          next_readdata = {29'h0, power_mode, auto_gating_select};
        end
        gate_bank_pkg::irq_status_offset: begin
          if (write && byteenable[0])
            next_status = irq_status & ~(writedata & gate_bank_pkg::irq_writable_mask);
          next_readdata = irq_status;
        end
        gate_bank_pkg::irq_mask_offset: begin
          if (write && byteenable[0])
            next_mask = writedata & gate_bank_pkg::irq_writable_mask;
          next_readdata = irq_mask;
        end
        gate_bank_pkg::fault_unit_offset: begin
          if (write)
            next_fault_unit = fault_unit & ~writedata;
          next_readdata = fault_unit;
        end
        default: next_response = resp_error;
      endcase
      if (!write)
        next_readdata = next_readdata;
      else
        next_readdata = readdata;
    end
    // Hardware set wins over a clear in the same cycle.
    if (fault_now) begin
      next_status[gate_bank_pkg::irq_fault_bit] = 1'b1; // R2
      next_fault_unit = next_fault_unit | fault_units_now;
    end
    if (next_mode != power_mode)
      next_status[gate_bank_pkg::irq_mode_bit] = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      run_peripheral_gate_one        <= gate_bank_pkg::gate_reset_value;
      sleep_peripheral_gate_one      <= gate_bank_pkg::gate_reset_value;
      deep_sleep_peripheral_gate_one <= gate_bank_pkg::gate_reset_value; // R3
      auto_gating_select             <= 1'b0;
      power_mode                     <= gate_bank_pkg::mode_run;
      irq_status                     <= 32'h00000000;
      irq_mask                       <= 32'h00000000;
      fault_unit                     <= 32'h00000000;
      served                         <= 1'b0;
      readdata                       <= 32'h00000000;
      response                       <= 2'b00;
      waitrequest                    <= 1'b1;
      unit_clock_enable              <= gate_bank_pkg::gate_reset_value; // R3
      unit_disable                   <= ~gate_bank_pkg::gate_reset_value;
      unit_bus_fault                 <= 1'b0;
      irq                            <= 1'b0;
    end else begin
      run_peripheral_gate_one        <= next_run;
      sleep_peripheral_gate_one      <= next_sleep;
      deep_sleep_peripheral_gate_one <= next_deep;
      auto_gating_select             <= next_auto;
      power_mode                     <= next_mode;
      irq_status                     <= next_status;
      irq_mask                       <= next_mask;
      fault_unit                     <= next_fault_unit;
      served                         <= next_served;
      readdata                       <= next_readdata;
      response                       <= next_response;
      waitrequest                    <= !((read || write) && !served);
      unit_clock_enable              <= next_enable; // R1
      unit_disable                   <= ~next_enable; // R1
      unit_bus_fault                 <= fault_now; // R2
      irq                            <= |(next_status & next_mask);
    end
  end

  // Reset and reserved bits.
  a_reset_clears: assert property (@(posedge clock) // R3
    $past(rst) |-> deep_sleep_peripheral_gate_one == gate_bank_pkg::gate_reset_value &&
      unit_clock_enable == gate_bank_pkg::gate_reset_value)
    else $error("reset did not clear gating");

  a_reserved_zero: assert property (@(posedge clock) disable iff (rst) // R9
    (deep_sleep_peripheral_gate_one & ~gate_bank_pkg::gate_writable_mask) == 32'h00000000)
    else $error("reserved gating bit set");

  a_run_reserved: assert property (@(posedge clock) disable iff (rst) // R9
    (run_peripheral_gate_one & ~gate_bank_pkg::gate_writable_mask) == 32'h00000000)
    else $error("reserved run gating bit set");

  a_sleep_reserved: assert property (@(posedge clock) disable iff (rst) // R9
    (sleep_peripheral_gate_one & ~gate_bank_pkg::gate_writable_mask) == 32'h00000000)
    else $error("reserved sleep gating bit set");

  // Unit faults and the interrupt.
  a_fault_flag: assert property (@(posedge clock) disable iff (rst) // R2
    |(unit_access & ~unit_clock_enable) |=>
      unit_bus_fault && irq_status[gate_bank_pkg::irq_fault_bit])
    else $error("gated unit access gave no fault");

  a_no_fault_clocked: assert property (@(posedge clock) disable iff (rst) // R2
    (unit_access & ~unit_clock_enable) == 32'h00000000 |=> !unit_bus_fault)
    else $error("fault on clocked unit");

  a_fault_latched: assert property (@(posedge clock) disable iff (rst) // R2
    fault_now |=> (fault_unit & $past(fault_units_now)) == $past(fault_units_now))
    else $error("faulting unit not recorded");

  a_fault_sticky: assert property (@(posedge clock) disable iff (rst) // R2
    irq_status[gate_bank_pkg::irq_fault_bit] &&
      !(write && address == gate_bank_pkg::irq_status_offset)
      |=> irq_status[gate_bank_pkg::irq_fault_bit])
    else $error("fault status lost without a clear");

  a_irq_level: assert property (@(posedge clock) disable iff (rst) // R2
    irq == |(irq_status & irq_mask))
    else $error("interrupt level disagrees with status");

  // Gating outputs per power mode, and the mode-change flag.
  a_enable_disable: assert property (@(posedge clock) disable iff (rst) // R1
    unit_disable == ~unit_clock_enable)
    else $error("disabled unit still clocked");

  a_enable_masked: assert property (@(posedge clock) disable iff (rst) // R1
    (unit_clock_enable & ~gate_bank_pkg::gate_writable_mask) == 32'h00000000)
    else $error("clock enabled on an absent unit");

  a_deep_gating: assert property (@(posedge clock) disable iff (rst) // R10
    power_mode == gate_bank_pkg::mode_deep_sleep && auto_gating_select |=>
      unit_clock_enable ==
        ($past(deep_sleep_peripheral_gate_one) & gate_bank_pkg::gate_writable_mask))
    else $error("deep-sleep gating not applied");

  a_no_auto_run: assert property (@(posedge clock) disable iff (rst) // R12
    power_mode == gate_bank_pkg::mode_deep_sleep && !auto_gating_select |=>
      unit_clock_enable ==
        ($past(run_peripheral_gate_one) & gate_bank_pkg::gate_writable_mask))
    else $error("run gating not kept in deep-sleep");

  a_run_mode_gate: assert property (@(posedge clock) disable iff (rst) // R10
    power_mode == gate_bank_pkg::mode_run |=>
      unit_clock_enable ==
        ($past(run_peripheral_gate_one) & gate_bank_pkg::gate_writable_mask))
    else $error("run mode not using run gating");

  a_sleep_auto_gate: assert property (@(posedge clock) disable iff (rst) // R10
    power_mode == gate_bank_pkg::mode_sleep && auto_gating_select |=>
      unit_clock_enable ==
        ($past(sleep_peripheral_gate_one) & gate_bank_pkg::gate_writable_mask))
    else $error("sleep gating not applied");

  a_sleep_no_auto: assert property (@(posedge clock) disable iff (rst) // R12
    power_mode == gate_bank_pkg::mode_sleep && !auto_gating_select |=>
      unit_clock_enable ==
        ($past(run_peripheral_gate_one) & gate_bank_pkg::gate_writable_mask))
    else $error("run gating not kept in sleep");

  a_mode_flag: assert property (@(posedge clock) disable iff (rst) // R10
    power_mode != $past(power_mode) |-> irq_status[gate_bank_pkg::irq_mode_bit])
    else $error("mode change not flagged");

  // Register bus handshake and decode.
  a_write_lands: assert property (@(posedge clock) disable iff (rst) // R4 R5 R6 R7 R8 R11
    write && !waitrequest && address == gate_bank_pkg::deep_sleep_gate_offset &&
      byteenable == 4'hF |=> deep_sleep_peripheral_gate_one ==
        ($past(writedata) & gate_bank_pkg::gate_writable_mask))
    else $error("gating write lost");

  a_read_data: assert property (@(posedge clock) disable iff (rst) // R4
    read && !served && address == gate_bank_pkg::deep_sleep_gate_offset
      |=> readdata == $past(deep_sleep_peripheral_gate_one))
    else $error("gating read data wrong");

  a_wait_one: assert property (@(posedge clock) disable iff (rst) // R4
    (read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held too long");

  a_idle_wait: assert property (@(posedge clock) disable iff (rst) // R4
    !read && !write |=> waitrequest)
    else $error("waitrequest low without a request");

  a_wait_served: assert property (@(posedge clock) disable iff (rst) // R4
    waitrequest == !served)
    else $error("waitrequest out of step with access state");

  a_unmapped_error: assert property (@(posedge clock) disable iff (rst) // R4
    (read || write) && !served && !is_mapped(address) |=> response == resp_error)
    else $error("unmapped access not refused");

  a_mapped_okay: assert property (@(posedge clock) disable iff (rst) // R4
    (read || write) && !served && is_mapped(address) |=> response == resp_okay)
    else $error("mapped access refused");

  a_unmapped_no_write: assert property (@(posedge clock) disable iff (rst) // R4
    write && !served && !is_mapped(address) |=> $stable(deep_sleep_peripheral_gate_one))
    else $error("unmapped write changed gating");
endmodule

// >>> hw/gate_bank_pkg.sv
// What this block does
// (R1) A set gating bit clocks and enables its unit; a clear bit stops and disables it.
// (R2) Any access to a unit whose clock is gated off returns a bus fault.
// (R3) Reset clears the whole gating register to zero, all units unclocked.
// (R4) Gating register decodes at offset 0x124 above base, one 32-bit word.
// (R5) Bits 19 to 16 gate counters 3 to 0, higher bit higher counter.
// (R6) Bit 12 gates two-wire module zero, readable and writable.
// (R7) Bit 4 gates synchronous serial module zero, readable and writable.
// (R8) Bits 1 and 0 gate asynchronous serial modules one and zero.
// (R9) Reserved bits are read-only zero; software writes back what it read.
// (R10) This register gates during deep-sleep; run and sleep use other registers.
// (R11) Bits 26, 25, 24 gate comparators 2, 1, 0 the same way.
// (R12) With auto gating select clear, deep-sleep keeps the run-mode gating.
package gate_bank_pkg;
  localparam logic [31:0] system_control_base = 32'h400FE000;
  localparam logic [11:0] deep_sleep_gate_offset = 12'h124;
  localparam logic [11:0] run_gate_offset        = 12'h100;
  localparam logic [11:0] sleep_gate_offset      = 12'h110;
  localparam logic [11:0] control_offset         = 12'h180;
  localparam logic [11:0] irq_status_offset      = 12'h184;
  localparam logic [11:0] irq_mask_offset        = 12'h188;
  localparam logic [11:0] fault_unit_offset      = 12'h18C;
  localparam logic [31:0] gate_reset_value       = 32'h00000000;
  localparam logic [31:0] gate_writable_mask     = 32'h070F1013;
  localparam int          unit_count             = 32;
  localparam int          control_auto_gating_bit = 0;
  localparam int          control_mode_lsb       = 1;
  localparam int          irq_fault_bit          = 0;
  localparam int          irq_mode_bit           = 1;
  localparam logic [31:0] irq_writable_mask      = 32'h00000003;
  localparam logic [31:0] unmapped_read_value    = 32'h00000000;
  typedef enum logic [1:0] {
    mode_run        = 2'b00,
    mode_sleep      = 2'b01,
    mode_deep_sleep = 2'b10,
    mode_spare      = 2'b11
  } power_mode_e;
endpackage

// >>> hw/unit_fault_check.sv
`timescale 1ns/1ps
// Flags a fault for a unit access whose clock is off; combinational, but the bank
// registers it, so unit_bus_fault answers the cycle after the access is seen.
module unit_fault_check #(
  parameter int units = gate_bank_pkg::unit_count
) (
  input  wire logic [units-1:0] unit_clock_on,
  input  wire logic [units-1:0] unit_access,
  output logic                  fault,
  output logic [units-1:0]      fault_units
);
  initial begin
    if (units < 1 || units > 32) $error("units must be 1 to 32");
  end
  always_comb begin
    fault_units = unit_access & ~unit_clock_on; // R2
    fault = |fault_units;
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clock;
  logic        rst;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  response;
  logic [31:0] unit_access;
  logic [31:0] unit_clock_enable;
  logic [31:0] unit_disable;
  logic        unit_bus_fault;
  logic        irq;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  int          n_fail;
  int          samples_checked;
  int          cycles;
  int          bit_list[11] = '{26, 25, 24, 19, 18, 17, 16, 12, 4, 1, 0};
  localparam logic [31:0] ds_auto = 32'h00000005;

  deep_sleep_clock_gate_bank_one deep_sleep_clock_gate_bank_one_inst (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .unit_access(unit_access),
    .unit_clock_enable(unit_clock_enable), .unit_disable(unit_disable),
    .unit_bus_fault(unit_bus_fault), .irq(irq));

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang anywhere is cut short here rather than left to run forever.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // The request is held until the edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      summarize();
    end
    rdata = readdata;
    rresp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic t_reset();
    bus(1'b0, 12'h124, 32'h00000000, 4'hF);
    chk_word(rdata, gate_bank_pkg::gate_reset_value, "gate after reset");
    chk_word(unit_clock_enable, 32'h00000000, "enables after reset");
    chk_word(unit_disable, 32'hFFFFFFFF, "disables after reset");
    $display("test reset done");
  endtask

  task automatic t_regfile();
    bus(1'b1, 12'h124, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 12'h124, 32'h00000000, 4'hF);
    chk_word(rdata, 32'h070F1013, "reserved bits read zero");
    chk_word({30'h0, rresp}, 32'h00000000, "okay response");
    bus(1'b1, 12'h124, 32'h00000000, 4'hF);
    bus(1'b1, 12'h124, 32'hFFFFFFFF, 4'h4);
    bus(1'b0, 12'h124, 32'h00000000, 4'hF);
    chk_word(rdata, 32'h000F0000, "one lane written");
    $display("test register done");
  endtask

  task automatic t_bits();
    logic [31:0] v;
    bus(1'b1, gate_bank_pkg::control_offset, ds_auto, 4'hF);
    foreach (bit_list[i]) begin
      v = 32'h00000001 << bit_list[i];
      bus(1'b1, 12'h124, v, 4'hF);
      bus(1'b0, 12'h124, 32'h00000000, 4'hF);
      chk_word(rdata, v, "single gate bit");
      settle();
      chk_word(unit_clock_enable, v, "unit clocked");
      chk_word(unit_disable, ~v, "others disabled");
    end
    $display("test gate bits done");
  endtask

  task automatic t_auto();
    bus(1'b1, 12'h124, 32'h00000013, 4'hF);
    bus(1'b1, gate_bank_pkg::control_offset, 32'h00000004, 4'hF);
    settle();
    chk_word(unit_clock_enable, 32'h00000000, "run gating without auto");
    bus(1'b1, gate_bank_pkg::control_offset, 32'h00000001, 4'hF);
    settle();
    chk_word(unit_clock_enable, 32'h00000000, "run mode ignores deep");
    bus(1'b1, gate_bank_pkg::control_offset, ds_auto, 4'hF);
    settle();
    chk_word(unit_clock_enable, 32'h00000013, "deep gating with auto");
    $display("test auto select done");
  endtask

  task automatic poke(input logic [31:0] u, input logic exp);
    @(posedge clock);
    unit_access <= u;
    @(posedge clock);
    unit_access <= 32'h00000000;
    #1;
    chk_bit(unit_bus_fault, exp, "fault pulse");
    @(posedge clock);
    #1;
    chk_bit(unit_bus_fault, 1'b0, "fault ends");
  endtask

  task automatic t_fault();
    // Mode changes in earlier tests left the mode flag set; clear both flags first.
    bus(1'b1, gate_bank_pkg::irq_status_offset, 32'h00000003, 4'hF);
    bus(1'b1, 12'h124, 32'h00000001, 4'hF);
    bus(1'b1, gate_bank_pkg::irq_mask_offset, 32'h00000001, 4'hF);
    settle();
    poke(32'h00000001, 1'b0);
    poke(32'h00000002, 1'b1);
    bus(1'b0, gate_bank_pkg::irq_status_offset, 32'h00000000, 4'hF);
    chk_word(rdata, 32'h00000001, "fault status");
    chk_bit(irq, 1'b1, "irq raised");
    bus(1'b1, gate_bank_pkg::irq_status_offset, 32'h00000001, 4'hF);
    settle();
    chk_bit(irq, 1'b0, "irq cleared");
    bus(1'b1, gate_bank_pkg::irq_mask_offset, 32'h00000000, 4'hF);
    poke(32'h01000000, 1'b1);
    settle();
    chk_bit(irq, 1'b0, "irq masked");
    bus(1'b0, 12'h1FC, 32'h00000000, 4'hF);
    chk_word({30'h0, rresp}, 32'h00000002, "unmapped error");
    chk_word(rdata, 32'h00000000, "unmapped data");
    $display("test fault done");
  endtask

  task automatic t_midreset();
    bus(1'b1, 12'h124, 32'h00000013, 4'hF);
    settle();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 12'h124, 32'h00000000, 4'hF);
    chk_word(rdata, gate_bank_pkg::gate_reset_value, "gate after second reset");
    chk_word(unit_clock_enable, 32'h00000000, "enables after second reset");
    chk_word(unit_disable, 32'hFFFFFFFF, "disables after second reset");
    $display("test mid reset done");
  endtask

  initial begin
    rst = 1'b1;
    address = 12'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    unit_access = 32'h00000000;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_regfile();
    t_bits();
    t_auto();
    t_fault();
    t_midreset();
    summarize();
  end
endmodule
